// ===== shared/urbs_pkg.sv
package urbs_pkg;

    // Register indices on the plain register port.
    localparam logic [1:0] ADDR_DATA = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_CTRLB = 2'h2;
    localparam logic [1:0] ADDR_CTRLC = 2'h3;

    // Status register field positions.
    localparam int unsigned ST_RXC = 7;
    localparam int unsigned ST_FE = 4;
    localparam int unsigned ST_DOR = 3;
    localparam int unsigned ST_UPE = 2;

    // Control register b field positions.
    localparam int unsigned CB_RXCIE = 7;
    localparam int unsigned CB_RXEN = 4;
    localparam int unsigned CB_CHSZ2 = 2;
    localparam int unsigned CB_RX9 = 1;
    localparam int unsigned CB_TX9 = 0;

    // Control register c field positions.
    localparam int unsigned CC_PM_HI = 5;
    localparam int unsigned CC_PM_LO = 4;
    localparam int unsigned CC_STOP = 3;
    localparam int unsigned CC_CHSZ_HI = 2;
    localparam int unsigned CC_CHSZ_LO = 1;

    // Reset values.
    localparam logic [7:0] CTRLB_RESET = 8'h00;
    localparam logic [7:0] CTRLC_RESET = 8'h06;

    // Character size code for nine data bits.
    localparam logic [2:0] CHSZ_NINE = 3'h7;

    // Oversampling: samples per bit, the three voting samples, decision point.
    localparam logic [4:0] SMP_LAST = 5'h10;
    localparam logic [4:0] SMP_VOTE_FIRST = 5'h08;
    localparam logic [4:0] SMP_VOTE_LAST = 5'h0a;
    localparam logic [4:0] SMP_DECIDE = 5'h0b;

    typedef struct packed {
        logic ninth;
        logic frameErr;
        logic overrun;
        logic parityErr;
        logic [7:0] data;
    } urbs_entry_t;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP = 3'b100
    } urbs_rx_state_t;

endpackage : urbs_pkg

// ===== shared/urbs_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface urbs_fifo_if #(
    parameter int PW = 1
);
    logic wrEn;
    logic [PW-1:0] wrAddr;
    logic [PW-1:0] rdAddr;
    urbs_pkg::urbs_entry_t wrData;
    urbs_pkg::urbs_entry_t rdData;

    modport mem (input wrEn, input wrAddr, input rdAddr, input wrData, output rdData);
    modport ctl (output wrEn, output wrAddr, output rdAddr, output wrData, input rdData);
endinterface : urbs_fifo_if
`default_nettype wire

// ===== rtl/urbs_entry_mem.sv
`timescale 1ns/1ps
`default_nettype none
module urbs_entry_mem #(
    parameter int DEPTH = 2,
    parameter int PW = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    urbs_fifo_if.mem port
);
    typedef struct packed {
        urbs_pkg::urbs_entry_t [DEPTH-1:0] slots;
        urbs_pkg::urbs_entry_t rd;
    } urbs_mem_state_t;

    urbs_mem_state_t s_q;
    urbs_mem_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (port.wrEn) begin
            s_d.slots[port.wrAddr] = port.wrData;
        end
        // Write-through keeps the head entry current in the cycle after a push.
        if (port.wrEn && (port.wrAddr == port.rdAddr)) begin
            s_d.rd = port.wrData;
        end else begin
            s_d.rd = s_q.slots[port.rdAddr];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign port.rdData = s_q.rd;
endmodule : urbs_entry_mem
`default_nettype wire

// ===== rtl/urbs_sample_vote.sv
`timescale 1ns/1ps
`default_nettype none
module urbs_sample_vote (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic capture,
    input wire logic pin,
    output logic vote
);
    typedef struct packed {
        logic [2:0] smp;
    } urbs_vote_state_t;

    urbs_vote_state_t s_q;
    urbs_vote_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (capture) begin
            s_d.smp = {s_q.smp[1:0], pin};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // Two of three high samples give a one.
    assign vote = (s_q.smp[0] & s_q.smp[1]) | (s_q.smp[0] & s_q.smp[2])
                | (s_q.smp[1] & s_q.smp[2]);
endmodule : urbs_sample_vote
`default_nettype wire

// ===== rtl/urbs_top.sv
// Functional notes
// - Ninth bit and errors stored per entry.
// - Receive-complete set while buffer non-empty.
// - Receiver disable flushes whole buffer.
// - Interrupt requested while enabled and complete.
// - Writes to error flags are ignored.
// - Error flags never raise interrupts.
// - Frame error mirrors first stop bit.
// - Only first stop bit is checked.
// - Overrun on full buffer, waiting frame, start.
// - Overrun clears on next buffer transfer.
// - Parity checked only when upper bit set.
// - Parity result stored with the entry.
// - Parity error zero when checking disabled.
// - Disable abandons frame in progress immediately.
// - Disabled receiver releases the receive pin.
// - Unused high data bits read zero.
// - Frame moves to buffer after stop.
// - Stop bit decided by majority vote.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module urbs_top #(
    parameter int FIFO_DEPTH = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [7:0] rdData,
    input wire logic serialReceivePin,
    input wire logic sampleTick,
    input wire logic globalIrqEnable,
    output logic rxCompleteIrq,
    output logic rxCompleteFlag,
    output logic rxPinOverride
);
    localparam int PW = (FIFO_DEPTH > 2) ? $clog2(FIFO_DEPTH) : 1;
    localparam logic [PW:0] FULL_COUNT = (PW+1)'(FIFO_DEPTH);

    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
            $error("FIFO_DEPTH must be a power of two, two or more");
        end
    endgenerate

    typedef struct packed {
        urbs_pkg::urbs_rx_state_t st;
        logic [4:0] smpCnt;
        logic [3:0] bitIdx;
        logic [8:0] shift;
        logic parBit;
        logic holdValid;
        urbs_pkg::urbs_entry_t hold;
        logic ovrPend;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [PW:0] count;
        logic rxcIe;
        logic rxEn;
        logic chsz2;
        logic txNinth;
        logic [1:0] parMode;
        logic stop2;
        logic [1:0] chszLo;
        logic [7:0] rdData;
        logic irq;
        logic rxc;
        logic pinOvr;
    } urbs_state_t;

    localparam urbs_state_t RST_STATE = '{
        st: urbs_pkg::RX_IDLE,
        rxcIe: urbs_pkg::CTRLB_RESET[urbs_pkg::CB_RXCIE],
        rxEn: urbs_pkg::CTRLB_RESET[urbs_pkg::CB_RXEN],
        chsz2: urbs_pkg::CTRLB_RESET[urbs_pkg::CB_CHSZ2],
        txNinth: urbs_pkg::CTRLB_RESET[urbs_pkg::CB_TX9],
        parMode: urbs_pkg::CTRLC_RESET[urbs_pkg::CC_PM_HI:urbs_pkg::CC_PM_LO],
        stop2: urbs_pkg::CTRLC_RESET[urbs_pkg::CC_STOP],
        chszLo: urbs_pkg::CTRLC_RESET[urbs_pkg::CC_CHSZ_HI:urbs_pkg::CC_CHSZ_LO],
        default: '0
    };

    urbs_state_t s_q;
    urbs_state_t s_d;

    urbs_fifo_if #(.PW(PW)) fifo ();

    logic vote;
    logic voteCapture;
    logic [2:0] charSize;
    logic [3:0] lastBit;
    logic nineBits;
    logic nonEmpty;
    logic pop;
    logic room;
    logic pushHold;
    logic pushFrame;
    logic frameDone;
    urbs_pkg::urbs_entry_t head;
    urbs_pkg::urbs_entry_t frame;

    urbs_entry_mem #(
        .DEPTH(FIFO_DEPTH),
        .PW(PW)
    ) u_mem (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .port(fifo.mem)
    );

    urbs_sample_vote u_vote (
        .clock(clock),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .capture(voteCapture),
        .pin(serialReceivePin),
        .vote(vote)
    );

    assign voteCapture = sampleTick && s_q.rxEn && (s_q.st != urbs_pkg::RX_IDLE)
                       && (s_q.smpCnt >= urbs_pkg::SMP_VOTE_FIRST)
                       && (s_q.smpCnt <= urbs_pkg::SMP_VOTE_LAST);

    assign head = fifo.rdData;
    assign charSize = {s_q.chsz2, s_q.chszLo};
    assign nineBits = (charSize == urbs_pkg::CHSZ_NINE);

    // Codes four to six are reserved and fall back to eight data bits.
    always_comb begin
        if (nineBits) begin
            lastBit = 4'h8;
        end else if (s_q.chsz2) begin
            lastBit = 4'h7;
        end else begin
            lastBit = {2'h1, s_q.chszLo};
        end
    end

    assign nonEmpty = (s_q.count != '0);
    assign pop = rdStrobe && (addr == urbs_pkg::ADDR_DATA) && nonEmpty;
    assign room = (s_q.count != FULL_COUNT) || pop;
    assign frameDone = sampleTick && s_q.rxEn && (s_q.st == urbs_pkg::RX_STOP)
                     && (s_q.smpCnt == urbs_pkg::SMP_DECIDE);
    assign pushHold = s_q.holdValid && room;
    assign pushFrame = frameDone && room && !pushHold;

    // Assemble the completed frame for the buffer.
    always_comb begin
        frame = '0;
        frame.data = s_q.shift[7:0];
        frame.ninth = nineBits && s_q.shift[8];
        frame.frameErr = !vote;
        frame.parityErr = s_q.parMode[1] && ((^s_q.shift) ^ s_q.parBit ^ s_q.parMode[0]);
    end

    always_comb begin
        s_d = s_q;
        fifo.wrEn = 1'b0;
        fifo.wrAddr = s_q.wrPtr;
        fifo.wrData = frame;

        // Register writes.
        if (wrStrobe) begin
            if (addr == urbs_pkg::ADDR_CTRLB) begin
                s_d.rxcIe = wrData[urbs_pkg::CB_RXCIE];
                s_d.rxEn = wrData[urbs_pkg::CB_RXEN];
                s_d.chsz2 = wrData[urbs_pkg::CB_CHSZ2];
                s_d.txNinth = wrData[urbs_pkg::CB_TX9];
            end else if (addr == urbs_pkg::ADDR_CTRLC) begin
                s_d.parMode = wrData[urbs_pkg::CC_PM_HI:urbs_pkg::CC_PM_LO];
                s_d.stop2 = wrData[urbs_pkg::CC_STOP];
                s_d.chszLo = wrData[urbs_pkg::CC_CHSZ_HI:urbs_pkg::CC_CHSZ_LO];
            end
        end

        // Register reads; the answer stands in the next cycle only.
        s_d.rdData = '0;
        if (rdStrobe) begin
            if (addr == urbs_pkg::ADDR_DATA) begin
                s_d.rdData = nonEmpty ? head.data : 8'h00;
            end else if (addr == urbs_pkg::ADDR_STATUS) begin
                s_d.rdData[urbs_pkg::ST_RXC] = nonEmpty;
                s_d.rdData[urbs_pkg::ST_FE] = nonEmpty && head.frameErr;
                s_d.rdData[urbs_pkg::ST_DOR] = nonEmpty && head.overrun;
                s_d.rdData[urbs_pkg::ST_UPE] = nonEmpty && head.parityErr;
            end else if (addr == urbs_pkg::ADDR_CTRLB) begin
                s_d.rdData[urbs_pkg::CB_RXCIE] = s_q.rxcIe;
                s_d.rdData[urbs_pkg::CB_RXEN] = s_q.rxEn;
                s_d.rdData[urbs_pkg::CB_CHSZ2] = s_q.chsz2;
                s_d.rdData[urbs_pkg::CB_RX9] = nonEmpty && head.ninth;
                s_d.rdData[urbs_pkg::CB_TX9] = s_q.txNinth;
            end else begin
                s_d.rdData[urbs_pkg::CC_PM_HI] = s_q.parMode[1];
                s_d.rdData[urbs_pkg::CC_PM_LO] = s_q.parMode[0];
                s_d.rdData[urbs_pkg::CC_STOP] = s_q.stop2;
                s_d.rdData[urbs_pkg::CC_CHSZ_HI] = s_q.chszLo[1];
                s_d.rdData[urbs_pkg::CC_CHSZ_LO] = s_q.chszLo[0];
            end
        end

        if (pop) begin
            s_d.rdPtr = s_q.rdPtr + 1'b1;
        end

        // A frame waiting in the hold register drains first.
        if (pushHold) begin
            fifo.wrEn = 1'b1;
            fifo.wrData = s_q.hold;
            fifo.wrData.overrun = s_q.ovrPend;
            s_d.ovrPend = 1'b0;
            s_d.holdValid = 1'b0;
        end

        // Receive sequencer, one step per oversampling tick.
        if (sampleTick && s_q.rxEn) begin
            if (s_q.smpCnt == urbs_pkg::SMP_LAST) begin
                s_d.smpCnt = 5'h01;
            end else begin
                s_d.smpCnt = s_q.smpCnt + 5'h01;
            end
            case (s_q.st)
                urbs_pkg::RX_IDLE: begin
                    s_d.smpCnt = 5'h01;
                    if (!serialReceivePin) begin
                        s_d.st = urbs_pkg::RX_START;
                        s_d.shift = '0;
                        s_d.parBit = 1'b0;
                        s_d.bitIdx = '0;
                        if (s_q.holdValid && !room) begin
                            s_d.ovrPend = 1'b1;
                            s_d.holdValid = 1'b0;
                        end
                    end
                end
                urbs_pkg::RX_START: begin
                    if (s_q.smpCnt == urbs_pkg::SMP_DECIDE && vote) begin
                        // A high vote marks a noise spike, so look again.
                        s_d.st = urbs_pkg::RX_IDLE;
                    end else if (s_q.smpCnt == urbs_pkg::SMP_LAST) begin
                        s_d.st = urbs_pkg::RX_DATA;
                    end
                end
                urbs_pkg::RX_DATA: begin
                    if (s_q.smpCnt == urbs_pkg::SMP_DECIDE) begin
                        s_d.shift[s_q.bitIdx] = vote;
                    end
                    if (s_q.smpCnt == urbs_pkg::SMP_LAST) begin
                        if (s_q.bitIdx == lastBit) begin
                            s_d.st = s_q.parMode[1] ? urbs_pkg::RX_PARITY : urbs_pkg::RX_STOP;
                        end else begin
                            s_d.bitIdx = s_q.bitIdx + 4'h1;
                        end
                    end
                end
                urbs_pkg::RX_PARITY: begin
                    if (s_q.smpCnt == urbs_pkg::SMP_DECIDE) begin
                        s_d.parBit = vote;
                    end
                    if (s_q.smpCnt == urbs_pkg::SMP_LAST) begin
                        s_d.st = urbs_pkg::RX_STOP;
                    end
                end
                urbs_pkg::RX_STOP: begin
                    if (s_q.smpCnt == urbs_pkg::SMP_DECIDE) begin
                        s_d.st = urbs_pkg::RX_IDLE;
                        if (pushFrame) begin
                            fifo.wrEn = 1'b1;
                            fifo.wrData = frame;
                            fifo.wrData.overrun = s_q.ovrPend;
                            s_d.ovrPend = 1'b0;
                        end else if (!pushHold) begin
                            s_d.holdValid = 1'b1;
                            s_d.hold = frame;
                        end
                    end
                end
                default: begin
                    s_d.st = urbs_pkg::RX_IDLE;
                end
            endcase
        end

        if (fifo.wrEn) begin
            s_d.wrPtr = s_q.wrPtr + 1'b1;
        end
        s_d.count = s_q.count + (PW+1)'(fifo.wrEn) - (PW+1)'(pop);

        if (!s_d.rxEn) begin
            s_d.st = urbs_pkg::RX_IDLE;
            s_d.smpCnt = '0;
            s_d.bitIdx = '0;
            s_d.count = '0;
            s_d.wrPtr = '0;
            s_d.rdPtr = '0;
            s_d.holdValid = 1'b0;
            s_d.ovrPend = 1'b0;
        end

        s_d.rxc = (s_d.count != '0);
        s_d.irq = s_d.rxcIe && s_d.rxc && globalIrqEnable;
        s_d.pinOvr = s_d.rxEn;

        // Reading the next pointer keeps the registered head current.
        fifo.rdAddr = s_d.rdPtr;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q <= RST_STATE;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.rdData;
    assign rxCompleteIrq = s_q.irq;
    assign rxCompleteFlag = s_q.rxc;
    assign rxPinOverride = s_q.pinOvr;
endmodule : urbs_top
`default_nettype wire

// ===== verif/urbs_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module urbs_top_props (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [7:0] rdData,
    input wire logic serialReceivePin,
    input wire logic sampleTick,
    input wire logic globalIrqEnable,
    input wire logic rxCompleteIrq,
    input wire logic rxCompleteFlag,
    input wire logic rxPinOverride
);
    logic offWr;
    logic popLike;
    logic stRead;
    assign offWr = wrStrobe && addr == urbs_pkg::ADDR_CTRLB && !wrData[urbs_pkg::CB_RXEN];
    assign popLike = offWr || (rdStrobe && addr == urbs_pkg::ADDR_DATA);
    assign stRead = rdStrobe && addr == urbs_pkg::ADDR_STATUS;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    AST_IRQ_GATED: assert property (rxCompleteIrq |-> rxCompleteFlag && $past(globalIrqEnable))
        else $error("interrupt without flag or global enable");
    AST_OFF_FLUSH: assert property (offWr |-> ##2 !rxCompleteFlag)
        else $error("flag survives receiver disable");
    AST_OFF_RELEASE: assert property (offWr |-> ##[1:2] !rxPinOverride)
        else $error("pin still overridden after disable");
    AST_RD_IDLE_ZERO: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
        else $error("read data outside answer cycle");
    AST_EMPTY_FLAGS: assert property ($past(stRead) && !rdData[7] |-> rdData[4:2] == 3'h0)
        else $error("error flags set with empty buffer");
    AST_FALL_CAUSE: assert property ($fell(rxCompleteFlag) |->
        $past(popLike) || $past(popLike, 2) || $past(popLike, 3))
        else $error("flag fell without data read or disable");
    AST_RISE_TICK: assert property ($rose(rxCompleteFlag) |->
        $past(sampleTick) || $past(sampleTick, 2) || $past(sampleTick, 3))
        else $error("flag rose away from a sample tick");
    AST_IRQ_STAYS: assert property (rxCompleteIrq && globalIrqEnable && !wrStrobe
        && !$past(wrStrobe) |=> rxCompleteIrq == rxCompleteFlag)
        else $error("interrupt does not follow flag");
    AST_DISABLED_EMPTY: assert property (!rxPinOverride [*3] |-> !rxCompleteFlag)
        else $error("flag set while receiver disabled");

    cover property ($rose(rxCompleteIrq));
    cover property ($past(stRead) && rdData[urbs_pkg::ST_DOR]);
    cover property ($past(stRead) && rdData[urbs_pkg::ST_FE]);
endmodule : urbs_top_props

bind urbs_top urbs_top_props u_props (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .serialReceivePin(serialReceivePin), .sampleTick(sampleTick),
    .globalIrqEnable(globalIrqEnable), .rxCompleteIrq(rxCompleteIrq),
    .rxCompleteFlag(rxCompleteFlag), .rxPinOverride(rxPinOverride)
);
`default_nettype wire

// ===== verif/urbs_serial_tx.sv
`timescale 1ns/1ps
`default_nettype none
module urbs_serial_tx (
    input wire logic clock,
    input wire logic sampleTick,
    output logic pin
);
    initial pin = 1'b1;

    task automatic hold(input logic v, input int n);
        pin <= v;
        repeat (16 * n) @(posedge clock iff sampleTick);
    endtask : hold

    // Only one stop bit is driven; the line then idles high, so a low stop bit never
    // turns into a second valid start that would add a stray frame.
    task automatic send(input logic [8:0] d, input int nb, input logic [1:0] pm,
        input logic flip, input logic stopV);
        logic par;
        par = ^(d & ((9'h001 << nb) - 9'h001)) ^ pm[0] ^ flip;
        @(posedge clock);
        hold(1'b0, 1);
        for (int i = 0; i < nb; i++) hold(d[i], 1);
        if (pm[1]) hold(par, 1);
        hold(stopV, 1);
        hold(1'b1, 2);
    endtask : send
endmodule : urbs_serial_tx
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock;
    logic rst_n;
    logic clkEn;
    logic [1:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] rdData;
    logic pin;
    logic sampleTick = 1'b0;
    logic [1:0] tickCnt = 2'h0;
    logic gie;
    logic irq;
    logic flag;
    logic ovr;
    int nErrors;
    int totalChecks;
    int seed = 32'h390c0488;

    urbs_top DUT (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .serialReceivePin(pin),
        .sampleTick(sampleTick), .globalIrqEnable(gie), .rxCompleteIrq(irq),
        .rxCompleteFlag(flag), .rxPinOverride(ovr));
    urbs_serial_tx tx (.clock(clock), .sampleTick(sampleTick), .pin(pin));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    always @(posedge clock) begin
        tickCnt <= tickCnt + 2'h1;
        sampleTick <= (tickCnt == 2'h3);
    end

    task automatic stopTest();
        $display("checks %0d errors %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stopTest

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        // The answer stands until this edge updates it, so take it here.
        @(posedge clock);
        v = rdData;
    endtask : rd

    function automatic int nbOf(input logic [2:0] c);
        return (c < 3'h4) ? int'(c) + 5 : ((c == 3'h7) ? 9 : 8);
    endfunction : nbOf

    function automatic logic [7:0] expData(input logic [8:0] d, input int nb);
        return (nb >= 8) ? d[7:0] : d[7:0] & ~(8'hff << nb);
    endfunction : expData

    function automatic logic [7:0] expStatus(input logic fe, input logic dor, input logic upe);
        return {1'b1, 2'h0, fe, dor, upe, 2'h0};
    endfunction : expStatus

    task automatic waitFlag();
        for (int i = 0; i < 200 && flag !== 1'b1; i++) @(posedge clock);
        check({7'h0, flag}, 8'h01);
    endtask : waitFlag

    task automatic readFrame(input logic [8:0] d, input int nb, input logic fe, input logic dor,
        input logic upe);
        logic [7:0] v;
        waitFlag();
        rd(urbs_pkg::ADDR_STATUS, v);
        check(v, expStatus(fe, dor, upe));
        rd(urbs_pkg::ADDR_CTRLB, v);
        if (nb == 9) check({7'h0, v[urbs_pkg::CB_RX9]}, {7'h0, d[8]});
        rd(urbs_pkg::ADDR_DATA, v);
        check(v, expData(d, nb));
    endtask : readFrame

    initial begin
        #400000;
        nErrors++;
        stopTest();
    end

    initial begin
        logic [7:0] v;
        logic [8:0] d;
        logic [8:0] q[4];
        logic [3:0] r;
        rst_n = 1'b0;
        clkEn = 1'b1;
        addr = 2'h0;
        wrData = 8'h00;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        gie = 1'b0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rd(urbs_pkg::ADDR_CTRLB, v);
        check(v, urbs_pkg::CTRLB_RESET);
        rd(urbs_pkg::ADDR_CTRLC, v);
        check(v, urbs_pkg::CTRLC_RESET);
        rd(urbs_pkg::ADDR_DATA, v);
        check(v, 8'h00);
        check({7'h0, ovr}, 8'h00);
        // Every size code against every parity mode, random data and faults.
        for (int k = 0; k < 32; k++) begin
            d = 9'($random(seed));
            r = 4'($random(seed));
            gie <= r[3];
            wr(urbs_pkg::ADDR_CTRLC, {2'h0, 2'(k >> 3), r[2], 2'(k), 1'b0});
            wr(urbs_pkg::ADDR_CTRLB, {r[0], 2'h0, 1'b1, 1'b0, 1'(k >> 2), 2'h0});
            tx.send(d, nbOf(3'(k)), 2'(k >> 3), r[1], r[2]);
            waitFlag();
            check({7'h0, irq}, {7'h0, r[0] & r[3]});
            check({7'h0, ovr}, 8'h01);
            if (k[0]) wr(urbs_pkg::ADDR_STATUS, 8'he3);
            readFrame(d, nbOf(3'(k)), !r[2], 1'b0, (k >= 16) && r[1]);
            repeat (3) @(posedge clock);
            check({6'h0, flag, irq}, 8'h00);
        end
        // Two buffered, one waiting, then a fourth start loses the third.
        wr(urbs_pkg::ADDR_CTRLC, 8'h06);
        for (int k = 0; k < 4; k++) begin
            q[k] = 9'($random(seed));
            tx.send(q[k], 8, 2'h0, 1'b0, 1'b1);
        end
        readFrame(q[0], 8, 1'b0, 1'b0, 1'b0);
        readFrame(q[1], 8, 1'b0, 1'b0, 1'b0);
        readFrame(q[3], 8, 1'b0, 1'b1, 1'b0);
        tx.send(q[2], 8, 2'h0, 1'b0, 1'b1);
        readFrame(q[2], 8, 1'b0, 1'b0, 1'b0);
        // Full buffer plus a frame in flight, then the receiver is switched off.
        repeat (2) tx.send(9'($random(seed)), 8, 2'h0, 1'b0, 1'b1);
        fork
            tx.send(9'h0a5, 8, 2'h0, 1'b0, 1'b1);
        join_none
        repeat (300) @(posedge clock);
        wr(urbs_pkg::ADDR_CTRLB, 8'h00);
        repeat (3) @(posedge clock);
        check({6'h0, flag, ovr}, 8'h00);
        rd(urbs_pkg::ADDR_STATUS, v);
        check(v, 8'h00);
        wait fork;
        wr(urbs_pkg::ADDR_CTRLB, 8'h10);
        tx.send(9'h05a, 8, 2'h0, 1'b0, 1'b1);
        readFrame(9'h05a, 8, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clock);
        check({7'h0, flag}, 8'h00);
        stopTest();
    end
endmodule : testbench
`default_nettype wire
